// ---- hdl/pco_clock_output.sv ----
/*
 * Programmable clock output unit: select register, port direction and port
 * latch registers, prescaler and glitch-free output gating onto the shared
 * port pin.
 * Assumes prs_tick pulses once per half period of the peripheral clock, and
 * sub_clk is the raw subsystem clock level, much slower than ref_clk.
 */
// What this block does
// - reset clears the select register to zero: output off, first source code
// - enable bit 0 stops the divider and holds the clock pin at port latch bit 2, low after reset
// - enable bit 1 runs the divider and drives the chosen clock on the pin
// - codes 0 to 7 give peripheral clock divided by two to the power code
// - code 8 passes the subsystem clock undivided; other codes are not used
// - switching enable on, or off with the source code unchanged, never makes a narrow pulse on the pin
// - output starts with a low phase and, if the disabling write keeps the source code, stops after a whole high phase
// - direction bit 0 turns the pin buffer on, 1 makes it an input
// - port direction register resets to all ones, every pin an input
// - select register takes bit writes and byte writes; bit writes touch one bit
`timescale 1ns/1ns

module pco_clock_output
    import pco_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            reset,
    input  wire logic            prs_tick,
    input  wire logic            sub_clk,
    input  wire pco_reg_req_type reg_req,
    output logic [7:0]           reg_rdata,
    output logic                 divided_clock_pin,
    output logic [7:0]           pin_drive_oe,
    output logic                 clk_running
);

    // register group
    logic [7:0]    clock_output_select_reg_ff;
    logic [7:0]    nxt_clock_output_select_reg;
    logic [7:0]    port_direction_reg_ff;
    logic [7:0]    nxt_port_direction_reg;
    logic [7:0]    port_latch_reg_ff;
    logic [7:0]    nxt_port_latch_reg;
    logic [7:0]    rdata_ff;
    logic [7:0]    nxt_rdata;

    // clock generation group
    logic          sub_meta_ff;
    logic          sub_sync_ff;
    logic [PCO_DIV_W-1:0] div_cnt_ff;
    logic [PCO_DIV_W-1:0] nxt_div_cnt;
    logic          clk_lvl_ff;
    logic          nxt_clk_lvl;
    pco_state_type state_ff;
    pco_state_type nxt_state;
    logic          pin_ff;
    logic          nxt_pin;
    logic [7:0]    oe_ff;
    logic [7:0]    nxt_oe;
    logic          running_ff;
    logic          nxt_running;

    // decoded select fields
    logic          output_enable_bit;
    logic [3:0]    src_sel;
    logic          src_is_div;
    logic          src_is_sub;
    logic [PCO_DIV_W-1:0] div_mask;
    logic          div_toggle;
    logic          src_next;

    assign output_enable_bit = clock_output_select_reg_ff[PCO_EN_BIT];
    assign src_sel           = clock_output_select_reg_ff[PCO_SRC_MSB:0];
    assign src_is_div        = (src_sel <= PCO_SRC_DIV_MAX);
    assign src_is_sub        = (src_sel == PCO_SRC_SUB);

    // low n bits of the tick count; all ones means 2**n - 1 ticks have passed, so this tick is the 2**n th
    assign div_mask   = PCO_DIV_W'((8'h01 << src_sel[2:0]) - 8'h01);
    assign div_toggle = prs_tick && ((div_cnt_ff & div_mask) == div_mask);

    // next level of the selected source while the output runs
    always_comb begin
        src_next = 1'b0;
        if (src_is_div) begin
            src_next = div_toggle ? ~clk_lvl_ff : clk_lvl_ff;
        end else if (src_is_sub) begin
            src_next = sub_sync_ff;
        end
    end

    // register writes and reads
    always_comb begin
        nxt_clock_output_select_reg = clock_output_select_reg_ff;
        nxt_port_direction_reg      = port_direction_reg_ff;
        nxt_port_latch_reg          = port_latch_reg_ff;
        nxt_rdata                   = rdata_ff;
        if (reg_req.byte_wr) begin
            case (reg_req.addr)
                PCO_ADDR_CLK_SEL: begin
                    nxt_clock_output_select_reg = reg_req.wdata & PCO_CLK_SEL_MASK;
                end
                PCO_ADDR_PORT_DIR: begin
                    nxt_port_direction_reg = reg_req.wdata;
                end
                PCO_ADDR_PORT_LAT: begin
                    nxt_port_latch_reg = reg_req.wdata;
                end
                default: begin
                    nxt_rdata = rdata_ff;
                end
            endcase
        end else if (reg_req.bit_wr) begin
            case (reg_req.addr)
                PCO_ADDR_CLK_SEL: begin
                    nxt_clock_output_select_reg[reg_req.bit_sel] = reg_req.bit_val;
                    nxt_clock_output_select_reg = nxt_clock_output_select_reg
                                                & PCO_CLK_SEL_MASK;
                end
                PCO_ADDR_PORT_DIR: begin
                    nxt_port_direction_reg[reg_req.bit_sel] = reg_req.bit_val;
                end
                PCO_ADDR_PORT_LAT: begin
                    nxt_port_latch_reg[reg_req.bit_sel] = reg_req.bit_val;
                end
                default: begin
                    nxt_rdata = rdata_ff;
                end
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                PCO_ADDR_CLK_SEL:  nxt_rdata = clock_output_select_reg_ff & PCO_CLK_SEL_MASK;
                PCO_ADDR_PORT_DIR: nxt_rdata = port_direction_reg_ff;
                PCO_ADDR_PORT_LAT: nxt_rdata = port_latch_reg_ff;
                default:           nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clock_output_select_reg_ff <= PCO_CLK_SEL_RST;
            port_direction_reg_ff      <= PCO_PORT_DIR_RST;
            port_latch_reg_ff          <= PCO_PORT_LAT_RST;
            rdata_ff                   <= 8'h00;
        end else begin
            clock_output_select_reg_ff <= nxt_clock_output_select_reg;
            port_direction_reg_ff      <= nxt_port_direction_reg;
            port_latch_reg_ff          <= nxt_port_latch_reg;
            rdata_ff                   <= nxt_rdata;
        end
    end

    // output sequencing: a disable that lands in a high phase lets that phase
    // finish at the rate of the selected code; an undefined code ends it at once
    always_comb begin
        nxt_state   = state_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_clk_lvl = clk_lvl_ff;
        case (state_ff)
            PCO_ST_IDLE: begin
                nxt_div_cnt = '0;
                nxt_clk_lvl = 1'b0;
                // sub clock start waits for its low phase to avoid a short high
                if (output_enable_bit && (src_is_div || (src_is_sub && !sub_sync_ff))) begin
                    nxt_state = PCO_ST_RUN;
                end
            end
            PCO_ST_RUN: begin
                if (!output_enable_bit || !(src_is_div || src_is_sub)) begin
                    if (clk_lvl_ff) begin
                        nxt_state = PCO_ST_DRAIN;
                        nxt_clk_lvl = src_next;
                        if (prs_tick) begin
                            nxt_div_cnt = div_cnt_ff + 1'b1;
                        end
                        if (!src_next) begin
                            nxt_state = PCO_ST_IDLE;
                        end
                    end else begin
                        nxt_state = PCO_ST_IDLE;
                    end
                end else begin
                    nxt_clk_lvl = src_next;
                    if (prs_tick) begin
                        nxt_div_cnt = div_cnt_ff + 1'b1;
                    end
                end
            end
            PCO_ST_DRAIN: begin
                nxt_clk_lvl = src_next;
                if (prs_tick) begin
                    nxt_div_cnt = div_cnt_ff + 1'b1;
                end
                if (!src_next) begin
                    nxt_state = PCO_ST_IDLE;
                end
            end
            default: begin
                nxt_state   = PCO_ST_IDLE;
                nxt_clk_lvl = 1'b0;
                nxt_div_cnt = '0;
            end
        endcase
    end

    // pin: latch is ored in, so software keeps it 0 for a clean clock
    always_comb begin
        nxt_pin     = nxt_clk_lvl | nxt_port_latch_reg[PCO_PIN_IDX];
        nxt_oe      = ~nxt_port_direction_reg;
        nxt_running = (nxt_state != PCO_ST_IDLE);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sub_meta_ff <= 1'b0;
            sub_sync_ff <= 1'b0;
            div_cnt_ff  <= '0;
            clk_lvl_ff  <= 1'b0;
            state_ff    <= PCO_ST_IDLE;
            pin_ff      <= 1'b0;
            oe_ff       <= 8'h00;
            running_ff  <= 1'b0;
        end else begin
            sub_meta_ff <= sub_clk;
            sub_sync_ff <= sub_meta_ff;
            div_cnt_ff  <= nxt_div_cnt;
            clk_lvl_ff  <= nxt_clk_lvl;
            state_ff    <= nxt_state;
            pin_ff      <= nxt_pin;
            oe_ff       <= nxt_oe;
            running_ff  <= nxt_running;
        end
    end

    assign reg_rdata         = rdata_ff;
    assign divided_clock_pin = pin_ff;
    assign pin_drive_oe      = oe_ff;
    assign clk_running       = running_ff;

endmodule // pco_clock_output

// ---- hdl/pco_pkg.sv ----
/*
 * Package for the programmable clock output unit: register addresses, field
 * positions, reset values, source codes, the register request carrier and
 * the output state encoding.
 * Assumes one 10 MHz clock and memory-mapped byte or bit register access.
 */
package pco_pkg;

    // register addresses on the internal data space
    localparam logic [15:0] PCO_ADDR_CLK_SEL   = 16'hff40;
    localparam logic [15:0] PCO_ADDR_PORT_DIR  = 16'hff24;
    localparam logic [15:0] PCO_ADDR_PORT_LAT  = 16'hff04;

    // reset values
    localparam logic [7:0]  PCO_CLK_SEL_RST    = 8'h00;
    localparam logic [7:0]  PCO_PORT_DIR_RST   = 8'hff;
    localparam logic [7:0]  PCO_PORT_LAT_RST   = 8'h00;

    // clock output select fields
    localparam int          PCO_EN_BIT         = 4;
    localparam int          PCO_SRC_MSB        = 3;
    localparam logic [7:0]  PCO_CLK_SEL_MASK   = 8'h1f;

    // source codes: 0..7 divide the peripheral clock by 2**n, 8 is the sub clock
    localparam logic [3:0]  PCO_SRC_DIV_MAX    = 4'h7;
    localparam logic [3:0]  PCO_SRC_SUB        = 4'h8;

    // port bit that carries the divided clock
    localparam int          PCO_PIN_IDX        = 2;

    // prescaler width covers divide by 128
    localparam int          PCO_DIV_W          = 7;

    // output frequency ceiling software must respect, in kHz
    localparam int          PCO_MAX_OUT_KHZ    = 10000;

    typedef struct packed {
        logic [15:0] addr;
        logic        byte_wr;
        logic        bit_wr;
        logic [2:0]  bit_sel;
        logic        bit_val;
        logic [7:0]  wdata;
        logic        rd;
    } pco_reg_req_type;

    typedef enum logic [2:0] {
        PCO_ST_IDLE  = 3'b001,
        PCO_ST_RUN   = 3'b010,
        PCO_ST_DRAIN = 3'b100
    } pco_state_type;

endpackage

// ---- tb/pco_properties.sv ----
/* assertions on the ports of the clock output unit
   assumes software keeps the port latch bit of the clock pin at 0 */
`timescale 1ns/1ns
module pco_properties
    import pco_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            reset,
    input wire logic            prs_tick,
    input wire logic            sub_clk,
    input wire pco_reg_req_type reg_req,
    input wire logic [7:0]      reg_rdata,
    input wire logic            divided_clock_pin,
    input wire logic [7:0]      pin_drive_oe,
    input wire logic            clk_running
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence sel_off_s;
        reg_req.byte_wr && reg_req.addr == PCO_ADDR_CLK_SEL && !reg_req.wdata[4];
    endsequence
    // only defined codes, started from idle, must come up
    sequence sel_on_s;
        reg_req.byte_wr && reg_req.addr == PCO_ADDR_CLK_SEL && reg_req.wdata[4]
            && reg_req.wdata[3:0] <= 4'h8 && !clk_running;
    endsequence
    disable_stop_a: assert property (sel_off_s |-> ##[1:1000] !clk_running)
        else $error("output kept running after disable");
    enable_start_a: assert property (sel_on_s |-> ##[1:60] clk_running)
        else $error("output did not start after enable");
    idle_low_a: assert property (!clk_running && !$past(clk_running) |-> !divided_clock_pin)
        else $error("clock pin high while idle");
    start_low_a: assert property ($rose(clk_running) |-> !$past(divided_clock_pin))
        else $error("output started in a high phase");
    stop_low_a: assert property ($fell(clk_running) |-> !divided_clock_pin)
        else $error("output stopped while high");
    high_width_a: assert property ($rose(divided_clock_pin) |-> divided_clock_pin [*3])
        else $error("narrow high pulse");
    low_width_a: assert property ($fell(divided_clock_pin) && clk_running
        |-> !divided_clock_pin [*3])
        else $error("narrow low pulse");
    unmapped_zero_a: assert property (reg_req.rd && reg_req.addr != PCO_ADDR_CLK_SEL
        && reg_req.addr != PCO_ADDR_PORT_DIR && reg_req.addr != PCO_ADDR_PORT_LAT
        |-> ##[1:2] reg_rdata == 8'h00) else $error("unmapped read not zero");
    upper_zero_a: assert property (reg_req.rd && reg_req.addr == PCO_ADDR_CLK_SEL
        |-> ##[1:2] reg_rdata[7:5] == 3'h0) else $error("select upper bits not zero");
    dir_oe_a: assert property (reg_req.byte_wr && reg_req.addr == PCO_ADDR_PORT_DIR
        |-> ##2 pin_drive_oe == ~$past(reg_req.wdata, 2)) else $error("drive enable wrong");
endmodule // pco_properties
bind pco_clock_output pco_properties i_pco_properties (.ref_clk, .reset, .prs_tick, .sub_clk,
    .reg_req, .reg_rdata, .divided_clock_pin, .pin_drive_oe, .clk_running);

// ---- tb/pco_clock_sink.sv ----
/* receiving chip model: measures phase widths of the divided clock
   assumes the pin only moves on rising edges of ref_clk */
`timescale 1ns/1ns
module pco_clock_sink (
    input  wire logic ref_clk,
    input  wire logic pin,
    output int        hi_len,
    output int        lo_len,
    output int        rises
);
    int   run_ff  = 0;
    logic last_ff = 1'b0;
    // widths in whole cycles, so a runt shows as a short count
    always @(posedge ref_clk) begin
        if (pin !== last_ff) begin
            if (last_ff === 1'b1) hi_len <= run_ff;
            else lo_len <= run_ff;
            if (pin === 1'b1) rises <= rises + 1;
            run_ff <= 1;
        end else run_ff <= run_ff + 1;
        last_ff <= pin;
    end
endmodule // pco_clock_sink

// ---- tb/tb_top.sv ----
/* bench for the clock output unit with a register model and a clock sink
   assumes prs_tick every 3 cycles and a sub clock half period of 16 cycles */
`timescale 1ns/1ns
module tb_top;
    import pco_pkg::*;
    logic            ref_clk, reset, prs_tick, sub_clk, divided_clock_pin, clk_running;
    logic [7:0]      reg_rdata, pin_drive_oe, d;
    logic [7:0]      m_reg [3];
    pco_reg_req_type reg_req;
    int              hi_len, lo_len, rises, error_cnt, num_checks, cyc, r0, e;
    pco_clock_output i_pco_clock_output (.ref_clk, .reset, .prs_tick, .sub_clk, .reg_req,
        .reg_rdata, .divided_clock_pin, .pin_drive_oe, .clk_running);
    pco_clock_sink i_pco_clock_sink (.ref_clk, .pin(divided_clock_pin), .hi_len, .lo_len,
        .rises);
    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        #1;
        cyc++;
        prs_tick = (cyc % 3 == 0);
        sub_clk = cyc[4];
        if (cyc > 20000) begin
            error_cnt++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic int idx(logic [15:0] a);
        return a == PCO_ADDR_CLK_SEL ? 0 : a == PCO_ADDR_PORT_DIR ? 1 :
            a == PCO_ADDR_PORT_LAT ? 2 : 3;
    endfunction
    task automatic req(logic [15:0] a, logic bw, logic bt, logic [2:0] bs, logic bv,
                       logic [7:0] dat, logic rd);
        @(posedge ref_clk);
        #1 reg_req = '{a, bw, bt, bs, bv, dat, rd};
        @(posedge ref_clk);
        #1 reg_req = '0;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] dat);
        req(a, 1, 0, 0, 0, dat, 0);
        if (idx(a) < 3) m_reg[idx(a)] = idx(a) == 0 ? dat & 8'h1f : dat;
    endtask
    task automatic rdc(logic [15:0] a);
        req(a, 0, 0, 0, 0, 8'h00, 1);
        @(posedge ref_clk);
        #1 chk(reg_rdata, idx(a) < 3 ? m_reg[idx(a)] : 8'h00);
    endtask
    task automatic wait_on(int lim, logic sel);
        for (int k = 0; k < lim && (sel ? rises < r0 + 3 : clk_running !== 1'b0); k++) begin
            @(posedge ref_clk);
            #2;
        end
    endtask
    initial begin
        reset = 1;
        reg_req = '0;
        prs_tick = 0;
        sub_clk = 0;
        cyc = 0;
        m_reg = '{8'h00, 8'hff, 8'h00};
        void'($urandom(43));
        repeat (5) @(posedge ref_clk);
        #1 reset = 0;
        for (int a = 0; a < 4; a++) rdc(a == 0 ? PCO_ADDR_CLK_SEL : a == 1 ?
            PCO_ADDR_PORT_DIR : a == 2 ? PCO_ADDR_PORT_LAT : 16'hff41);
        chk(pin_drive_oe, 8'h00);
        d = 8'($urandom);
        wr(PCO_ADDR_PORT_DIR, d);
        rdc(PCO_ADDR_PORT_DIR);
        chk(pin_drive_oe, 8'(~d));
        wr(PCO_ADDR_CLK_SEL, 8'($urandom) & 8'hef);
        rdc(PCO_ADDR_CLK_SEL);
        req(PCO_ADDR_CLK_SEL, 0, 1, 3'h7, 1, 8'h00, 0);
        rdc(PCO_ADDR_CLK_SEL);
        wr(PCO_ADDR_PORT_DIR, 8'hfb);
        wr(PCO_ADDR_PORT_LAT, 8'h00);
        for (int n = 0; n <= 9; n++) begin
            e = n == 8 ? 16 : 3 << n;
            wr(PCO_ADDR_CLK_SEL, 8'(n));
            if (n == 4) begin
                req(PCO_ADDR_CLK_SEL, 0, 1, 3'h4, 1, 8'h00, 0);
                m_reg[0][4] = 1'b1;
            end else wr(PCO_ADDR_CLK_SEL, 8'(n) | 8'h10);
            rdc(PCO_ADDR_CLK_SEL);
            r0 = rises;
            wait_on(n == 9 ? 200 : 3000, 1);
            if (n < 9) begin
                chk(hi_len, e);
                chk(lo_len, e);
                for (int k = 0; k < 500 && divided_clock_pin !== 1'b1; k++) @(negedge ref_clk);
                wr(PCO_ADDR_CLK_SEL, 8'(n));
                wait_on(1000, 0);
                chk(hi_len, e);
            end else chk(rises, r0);
            chk(divided_clock_pin, 0);
        end
        wr(PCO_ADDR_CLK_SEL, 8'h10);
        repeat (20) @(posedge ref_clk);
        #1 reset = 1;
        repeat (2) @(posedge ref_clk);
        #1 reset = 0;
        m_reg = '{8'h00, 8'hff, 8'h00};
        rdc(PCO_ADDR_CLK_SEL);
        chk(divided_clock_pin, 0);
        print_verdict;
    end
endmodule // tb_top
